// *** logic/jtag_dbg_pkg.sv ***
// constants, types and tables of the jtag debug and security subsystem
// assumes a single system clock; all scan pins are sampled into that clock
package jtag_dbg_pkg;
    localparam int          KEY_W           = 128;
    localparam int          IR_W            = 4;
    localparam int          WORD_W          = 32;
    localparam int          SEC_TAP_INDEX   = 2;
    // unlock path
    localparam logic [127:0] DEFAULT_VISIBLE_CODE = {128{1'b1}};
    localparam logic [127:0] HIDDEN_TIE_OFF       = 128'h5a3c_96e1_0f7b_2d48_c3a5_1e69_b7d0_4f82;
    localparam logic [127:0] HIDDEN_MATCH         = DEFAULT_VISIBLE_CODE ^ HIDDEN_TIE_OFF;
    localparam logic [31:0] OTP_CODE_BASE   = 32'hf000_0000;
    localparam logic [31:0] OTP_CODE_MASK   = 32'hffff_fff0;
    // instruction codes of the security unit tap
    localparam logic [3:0]  IR_KEY          = 4'hb;
    localparam logic [3:0]  IR_IDCODE       = 4'he;
    localparam logic [3:0]  IR_BOUNDARY     = 4'h0;
    localparam logic [3:0]  IR_BYPASS       = 4'hf;
    localparam logic [3:0]  IR_CAPTURE      = 4'h1;
    // identification, value arbitrary
    localparam logic [27:0] ID_BASE         = 28'h5a5_0001;
    // debug frames
    localparam logic [31:0] ROM_FRAME_BASE  = 32'hffa0_0000;
    localparam logic [31:0] CPU_FRAME_BASE  = 32'hffa0_1000;
    localparam logic [31:0] FRAME_MASK      = 32'hffff_f000;
    // debug rom table, index = word offset
    localparam logic [9:0]  ROM_IDX_CPU     = 10'h000;
    localparam logic [9:0]  ROM_IDX_RSV1    = 10'h001;
    localparam logic [9:0]  ROM_IDX_RSV2    = 10'h002;
    localparam logic [9:0]  ROM_IDX_RSV3    = 10'h003;
    localparam logic [9:0]  ROM_IDX_END     = 10'h004;
    localparam logic [31:0] ROM_CPU_PTR     = 32'h0000_1003;
    localparam logic [31:0] ROM_RSV1        = 32'h0000_2002;
    localparam logic [31:0] ROM_RSV2        = 32'h0000_3002;
    localparam logic [31:0] ROM_RSV3        = 32'h0000_4003;
    localparam logic [31:0] ROM_END         = 32'h0000_0000;

    typedef enum logic [3:0] {
        TEST_LOGIC_RESET, RUN_IDLE, SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
        UPDATE_DR, SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
    } tap_state_t;

    typedef enum logic [1:0] {CHAIN_KEY, CHAIN_ID, CHAIN_BOUNDARY, CHAIN_BYPASS} chain_t;
endpackage

// *** logic/jtag_debug_security_subsystem.sv ***
// jtag security unit, tap routing gate, debug frame decode, debug rom, idcode, boundary chain
// assumes tck/tms/tdi/boundary pins are asynchronous; debug bus and otp port are on sys_clk
`timescale 1ns/1ps
module jtag_debug_security_subsystem #(
    parameter int          NUM_SEC_TAPS = 4,
    parameter int          BSC_LEN      = 16,
    parameter logic [3:0]  SILICON_REV  = 4'h0
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic                 power_on_reset_n,
    input  wire logic                 tck,
    input  wire logic                 tms,
    input  wire logic                 tdi,
    output logic                      tdo,
    output logic                      tdo_oe_n,
    output logic                      returned_test_clock,
    input  wire logic [BSC_LEN-1:0]   bsc_pin_in,
    output logic [BSC_LEN-1:0]        bsc_pin_out,
    input  wire logic                 otp_prog_we,
    input  wire logic [31:0]          otp_prog_addr,
    input  wire logic [31:0]          otp_prog_wdata,
    output logic                      unlock,
    output logic [NUM_SEC_TAPS-1:0]   secondary_tap_enable,
    output logic                      test_tap_enable,
    output logic                      boundary_scan_enable,
    input  wire logic                 dbg_sel,
    input  wire logic                 dbg_write,
    input  wire logic [31:0]          dbg_addr,
    input  wire logic [31:0]          cpu_debug_rdata,
    output logic [31:0]               dbg_rdata,
    output logic                      dbg_ready,
    output logic                      debug_rom_frame_select,
    output logic                      cpu_debug_frame_select
);
    if (NUM_SEC_TAPS <= jtag_dbg_pkg::SEC_TAP_INDEX) begin : g_chk_taps
        $error("NUM_SEC_TAPS must exceed the security tap index");
    end
    if (BSC_LEN < 2) begin : g_chk_bsc
        $error("BSC_LEN must be at least 2");
    end

    localparam int KW = jtag_dbg_pkg::KEY_W;

    function automatic jtag_dbg_pkg::chain_t route_chain(input logic [3:0] ir, input logic open_access);
        if (ir == jtag_dbg_pkg::IR_KEY) begin
            route_chain = jtag_dbg_pkg::CHAIN_KEY;
        end else if (!open_access) begin
            route_chain = jtag_dbg_pkg::CHAIN_BYPASS;
        end else if (ir == jtag_dbg_pkg::IR_IDCODE) begin
            route_chain = jtag_dbg_pkg::CHAIN_ID;
        end else if (ir == jtag_dbg_pkg::IR_BOUNDARY) begin
            route_chain = jtag_dbg_pkg::CHAIN_BOUNDARY;
        end else begin
            route_chain = jtag_dbg_pkg::CHAIN_BYPASS;
        end
    endfunction

    function automatic logic [31:0] rom_entry(input logic [9:0] idx);
        if (idx == jtag_dbg_pkg::ROM_IDX_CPU) begin
            rom_entry = jtag_dbg_pkg::ROM_CPU_PTR;
        end else if (idx == jtag_dbg_pkg::ROM_IDX_RSV1) begin
            rom_entry = jtag_dbg_pkg::ROM_RSV1;
        end else if (idx == jtag_dbg_pkg::ROM_IDX_RSV2) begin
            rom_entry = jtag_dbg_pkg::ROM_RSV2;
        end else if (idx == jtag_dbg_pkg::ROM_IDX_RSV3) begin
            rom_entry = jtag_dbg_pkg::ROM_RSV3;
        end else if (idx == jtag_dbg_pkg::ROM_IDX_END) begin
            rom_entry = jtag_dbg_pkg::ROM_END;
        end else begin
            rom_entry = '0;
        end
    endfunction

    // pin synchronisers
    logic [1:0]         tck_sync_reg;
    logic [1:0]         tms_sync_reg;
    logic [1:0]         tdi_sync_reg;
    logic               tck_prev_reg;
    logic [BSC_LEN-1:0] bsc_s1_reg;
    logic [BSC_LEN-1:0] bsc_s2_reg;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tck_sync_reg <= '0;
            tms_sync_reg <= 2'h3;
            tdi_sync_reg <= '0;
            tck_prev_reg <= 1'b0;
            bsc_s1_reg   <= '0;
            bsc_s2_reg   <= '0;
        end else begin
            tck_sync_reg <= {tck_sync_reg[0], tck};
            tms_sync_reg <= {tms_sync_reg[0], tms};
            tdi_sync_reg <= {tdi_sync_reg[0], tdi};
            tck_prev_reg <= tck_sync_reg[1];
            bsc_s1_reg   <= bsc_pin_in;
            bsc_s2_reg   <= bsc_s1_reg;
        end
    end

    wire logic tck_rise = tck_sync_reg[1] & ~tck_prev_reg;
    wire logic tck_fall = ~tck_sync_reg[1] & tck_prev_reg;
    wire logic tms_s    = tms_sync_reg[1];
    wire logic tdi_s    = tdi_sync_reg[1];

    jtag_dbg_pkg::tap_state_t tap_state;

    tap_controller u_tap (
        .sys_clk (sys_clk),
        .rst     (rst),
        .step    (tck_rise),
        .tms     (tms_s),
        .state   (tap_state)
    );

    // security state: key, code and unlock survive every reset except power-on; the key shift register is cleared by rst
    logic [127:0] key_reg;
    logic [127:0] key_next;
    logic [127:0] code_reg;
    logic [127:0] code_next;
    logic         unlock_reg;
    logic         unlock_next;
    logic [KW-1:0] key_shift_reg;
    logic          key_load;

    always_comb begin
        key_next  = key_load ? key_shift_reg : key_reg;
        code_next = code_reg;
        if (otp_prog_we && ((otp_prog_addr & jtag_dbg_pkg::OTP_CODE_MASK) == jtag_dbg_pkg::OTP_CODE_BASE)) begin
            // programming can only clear bits
            code_next[otp_prog_addr[3:2]*32 +: 32] = code_reg[otp_prog_addr[3:2]*32 +: 32] & otp_prog_wdata;
        end
        unlock_next = ((((code_reg ^ key_reg) ^ jtag_dbg_pkg::HIDDEN_TIE_OFF) == jtag_dbg_pkg::HIDDEN_MATCH)
                      && (code_reg != '0));
    end

    always_ff @(posedge sys_clk or negedge power_on_reset_n) begin
        if (!power_on_reset_n) begin
            key_reg    <= '0;
            code_reg   <= jtag_dbg_pkg::DEFAULT_VISIBLE_CODE;
            unlock_reg <= 1'b0;
        end else begin
            key_reg    <= key_next;
            code_reg   <= code_next;
            unlock_reg <= unlock_next;
        end
    end

    // scan chains and routing gate
    logic [3:0]            ir_shift_reg;
    logic [3:0]            ir_shift_next;
    logic [3:0]            ir_reg;
    logic [3:0]            ir_next;
    logic [KW-1:0]         key_shift_next;
    logic [31:0]           id_shift_reg;
    logic [31:0]           id_shift_next;
    logic [BSC_LEN-1:0]    bsc_shift_reg;
    logic [BSC_LEN-1:0]    bsc_shift_next;
    logic [BSC_LEN-1:0]    bsc_out_reg;
    logic [BSC_LEN-1:0]    bsc_out_next;
    logic                  bypass_reg;
    logic                  bypass_next;
    logic                  tdo_reg;
    logic                  tdo_next;
    logic                  tdo_oe_n_reg;
    logic                  tdo_oe_n_next;
    logic                  returned_test_clock_reg;
    logic [NUM_SEC_TAPS-1:0] sec_en_reg;
    logic [NUM_SEC_TAPS-1:0] sec_en_next;
    logic                  open_reg;
    jtag_dbg_pkg::chain_t  chain;

    always_comb begin
        chain          = route_chain(ir_reg, unlock_reg);
        ir_shift_next  = ir_shift_reg;
        ir_next        = ir_reg;
        key_shift_next = key_shift_reg;
        id_shift_next  = id_shift_reg;
        bsc_shift_next = bsc_shift_reg;
        bsc_out_next   = bsc_out_reg;
        bypass_next    = bypass_reg;
        tdo_next       = tdo_reg;
        tdo_oe_n_next  = tdo_oe_n_reg;
        key_load       = 1'b0;
        sec_en_next    = unlock_reg ? {NUM_SEC_TAPS{1'b1}}
                                    : NUM_SEC_TAPS'(1) << jtag_dbg_pkg::SEC_TAP_INDEX;
        if (tck_rise) begin
            case (tap_state)
                jtag_dbg_pkg::TEST_LOGIC_RESET: ir_next = jtag_dbg_pkg::IR_IDCODE;
                jtag_dbg_pkg::CAPTURE_IR: ir_shift_next = jtag_dbg_pkg::IR_CAPTURE;
                jtag_dbg_pkg::SHIFT_IR:   ir_shift_next = {tdi_s, ir_shift_reg[3:1]};
                jtag_dbg_pkg::UPDATE_IR:  ir_next = ir_shift_reg;
                jtag_dbg_pkg::CAPTURE_DR: begin
                    key_shift_next = '0;
                    id_shift_next  = {SILICON_REV, jtag_dbg_pkg::ID_BASE};
                    bsc_shift_next = bsc_s2_reg;
                    bypass_next    = 1'b0;
                end
                jtag_dbg_pkg::SHIFT_DR: begin
                    case (chain)
                        jtag_dbg_pkg::CHAIN_KEY:      key_shift_next = {tdi_s, key_shift_reg[KW-1:1]};
                        jtag_dbg_pkg::CHAIN_ID:       id_shift_next = {tdi_s, id_shift_reg[31:1]};
                        jtag_dbg_pkg::CHAIN_BOUNDARY: bsc_shift_next = {tdi_s, bsc_shift_reg[BSC_LEN-1:1]};
                        default:                      bypass_next = tdi_s;
                    endcase
                end
                jtag_dbg_pkg::UPDATE_DR: begin
                    if (chain == jtag_dbg_pkg::CHAIN_KEY) begin
                        key_load = 1'b1;
                    end else if (chain == jtag_dbg_pkg::CHAIN_BOUNDARY) begin
                        bsc_out_next = bsc_shift_reg;
                    end
                end
                default: ;
            endcase
        end
        if (tck_fall) begin
            tdo_oe_n_next = !((tap_state == jtag_dbg_pkg::SHIFT_IR) || (tap_state == jtag_dbg_pkg::SHIFT_DR));
            if (tap_state == jtag_dbg_pkg::SHIFT_IR) begin
                tdo_next = ir_shift_reg[0];
            end else begin
                case (chain)
                    jtag_dbg_pkg::CHAIN_KEY:      tdo_next = key_shift_reg[0];
                    jtag_dbg_pkg::CHAIN_ID:       tdo_next = id_shift_reg[0];
                    jtag_dbg_pkg::CHAIN_BOUNDARY: tdo_next = bsc_shift_reg[0];
                    default:                      tdo_next = bypass_reg;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ir_shift_reg  <= '0;
            ir_reg        <= jtag_dbg_pkg::IR_IDCODE;
            key_shift_reg <= '0;
            id_shift_reg  <= '0;
            bsc_shift_reg <= '0;
            bsc_out_reg   <= '0;
            bypass_reg    <= 1'b0;
            tdo_reg       <= 1'b0;
            tdo_oe_n_reg  <= 1'b1;
            returned_test_clock_reg      <= 1'b0;
            sec_en_reg    <= '0;
            open_reg      <= 1'b0;
        end else begin
            ir_shift_reg  <= ir_shift_next;
            ir_reg        <= ir_next;
            key_shift_reg <= key_shift_next;
            id_shift_reg  <= id_shift_next;
            bsc_shift_reg <= bsc_shift_next;
            bsc_out_reg   <= bsc_out_next;
            bypass_reg    <= bypass_next;
            tdo_reg       <= tdo_next;
            tdo_oe_n_reg  <= tdo_oe_n_next;
            returned_test_clock_reg      <= tck_sync_reg[1];
            sec_en_reg    <= sec_en_next;
            open_reg      <= unlock_reg;
        end
    end

    // debug frame decode
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        ready_reg;
    logic        rom_sel_reg;
    logic        rom_sel_next;
    logic        cpu_sel_reg;
    logic        cpu_sel_next;

    always_comb begin
        rdata_next   = '0;
        rom_sel_next = 1'b0;
        cpu_sel_next = 1'b0;
        if (dbg_sel && ((dbg_addr & jtag_dbg_pkg::FRAME_MASK) == jtag_dbg_pkg::ROM_FRAME_BASE)) begin
            rom_sel_next = 1'b1;
            if (!dbg_write) begin
                rdata_next = rom_entry(dbg_addr[11:2]);
            end
        end else if (dbg_sel && ((dbg_addr & jtag_dbg_pkg::FRAME_MASK) == jtag_dbg_pkg::CPU_FRAME_BASE)) begin
            cpu_sel_next = 1'b1;
            if (!dbg_write) begin
                rdata_next = cpu_debug_rdata;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata_reg   <= '0;
            ready_reg   <= 1'b0;
            rom_sel_reg <= 1'b0;
            cpu_sel_reg <= 1'b0;
        end else begin
            rdata_reg   <= rdata_next;
            ready_reg   <= dbg_sel;
            rom_sel_reg <= rom_sel_next;
            cpu_sel_reg <= cpu_sel_next;
        end
    end

    assign tdo                    = tdo_reg;
    assign tdo_oe_n               = tdo_oe_n_reg;
    assign returned_test_clock    = returned_test_clock_reg;
    assign bsc_pin_out            = bsc_out_reg;
    assign unlock                 = unlock_reg;
    assign secondary_tap_enable   = sec_en_reg;
    assign test_tap_enable        = open_reg;
    assign boundary_scan_enable   = open_reg;
    assign dbg_rdata              = rdata_reg;
    assign dbg_ready              = ready_reg;
    assign debug_rom_frame_select = rom_sel_reg;
    assign cpu_debug_frame_select = cpu_sel_reg;
endmodule

// *** logic/tap_controller.sv ***
// ieee 1149.1 tap state machine stepped by detected tck rising edges
// assumes step is a one-cycle pulse and tms already synchronised
`timescale 1ns/1ps
module tap_controller (
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    input  wire logic                    step,
    input  wire logic                    tms,
    output jtag_dbg_pkg::tap_state_t     state
);
    jtag_dbg_pkg::tap_state_t state_reg;
    jtag_dbg_pkg::tap_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (step) begin
            case (state_reg)
                jtag_dbg_pkg::TEST_LOGIC_RESET: state_next = tms ? jtag_dbg_pkg::TEST_LOGIC_RESET : jtag_dbg_pkg::RUN_IDLE;
                jtag_dbg_pkg::RUN_IDLE:   state_next = tms ? jtag_dbg_pkg::SELECT_DR : jtag_dbg_pkg::RUN_IDLE;
                jtag_dbg_pkg::SELECT_DR:  state_next = tms ? jtag_dbg_pkg::SELECT_IR : jtag_dbg_pkg::CAPTURE_DR;
                jtag_dbg_pkg::CAPTURE_DR: state_next = tms ? jtag_dbg_pkg::EXIT1_DR : jtag_dbg_pkg::SHIFT_DR;
                jtag_dbg_pkg::SHIFT_DR:   state_next = tms ? jtag_dbg_pkg::EXIT1_DR : jtag_dbg_pkg::SHIFT_DR;
                jtag_dbg_pkg::EXIT1_DR:   state_next = tms ? jtag_dbg_pkg::UPDATE_DR : jtag_dbg_pkg::PAUSE_DR;
                jtag_dbg_pkg::PAUSE_DR:   state_next = tms ? jtag_dbg_pkg::EXIT2_DR : jtag_dbg_pkg::PAUSE_DR;
                jtag_dbg_pkg::EXIT2_DR:   state_next = tms ? jtag_dbg_pkg::UPDATE_DR : jtag_dbg_pkg::SHIFT_DR;
                jtag_dbg_pkg::UPDATE_DR:  state_next = tms ? jtag_dbg_pkg::SELECT_DR : jtag_dbg_pkg::RUN_IDLE;
                jtag_dbg_pkg::SELECT_IR:  state_next = tms ? jtag_dbg_pkg::TEST_LOGIC_RESET : jtag_dbg_pkg::CAPTURE_IR;
                jtag_dbg_pkg::CAPTURE_IR: state_next = tms ? jtag_dbg_pkg::EXIT1_IR : jtag_dbg_pkg::SHIFT_IR;
                jtag_dbg_pkg::SHIFT_IR:   state_next = tms ? jtag_dbg_pkg::EXIT1_IR : jtag_dbg_pkg::SHIFT_IR;
                jtag_dbg_pkg::EXIT1_IR:   state_next = tms ? jtag_dbg_pkg::UPDATE_IR : jtag_dbg_pkg::PAUSE_IR;
                jtag_dbg_pkg::PAUSE_IR:   state_next = tms ? jtag_dbg_pkg::EXIT2_IR : jtag_dbg_pkg::PAUSE_IR;
                jtag_dbg_pkg::EXIT2_IR:   state_next = tms ? jtag_dbg_pkg::UPDATE_IR : jtag_dbg_pkg::SHIFT_IR;
                default:                  state_next = tms ? jtag_dbg_pkg::SELECT_DR : jtag_dbg_pkg::RUN_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg <= jtag_dbg_pkg::TEST_LOGIC_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign state = state_reg;
endmodule

// *** test/jtag_dbg_asserts.sv ***
// checker of debug bus answers, rom table, lock gating and reset effects
// assumes binding onto the subsystem top; watches its ports only
`timescale 1ns/1ps
module jtag_dbg_asserts #(
    parameter int NUM_SEC_TAPS = 4
) (
    input wire logic                    sys_clk,
    input wire logic                    rst,
    input wire logic                    power_on_reset_n,
    input wire logic                    unlock,
    input wire logic [NUM_SEC_TAPS-1:0] secondary_tap_enable,
    input wire logic                    test_tap_enable,
    input wire logic                    boundary_scan_enable,
    input wire logic                    dbg_sel,
    input wire logic                    dbg_write,
    input wire logic [31:0]             dbg_addr,
    input wire logic [31:0]             cpu_debug_rdata,
    input wire logic [31:0]             dbg_rdata,
    input wire logic                    dbg_ready,
    input wire logic                    debug_rom_frame_select,
    input wire logic                    cpu_debug_frame_select
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic rd;
    assign rd = dbg_sel && !dbg_write;
    a_ready_follows: assert property (dbg_sel |=> dbg_ready) else $error("no ready after request");
    a_rom_select: assert property (rd && dbg_addr[31:12] == 20'hffa00 |=> debug_rom_frame_select
        && !cpu_debug_frame_select) else $error("rom frame not selected");
    a_rom_first: assert property (rd && dbg_addr == jtag_dbg_pkg::ROM_FRAME_BASE
        |=> dbg_rdata == 32'h0000_1003) else $error("wrong first rom entry");
    a_rom_end: assert property (rd && dbg_addr == 32'hffa0_0010 |=> dbg_rdata == 32'h0)
        else $error("wrong rom terminator");
    a_outside_zero: assert property (rd && dbg_addr[31:13] != 19'h7fd00 |=> dbg_rdata == 32'h0
        && !debug_rom_frame_select && !cpu_debug_frame_select) else $error("outside access answered");
    a_cpu_passthru: assert property (rd && dbg_addr[31:12] == 20'hffa01 |=> cpu_debug_frame_select
        && dbg_rdata == $past(cpu_debug_rdata)) else $error("cpu frame data lost");
    // enables restart from zero after rst (power-on reset alone leaves them), so skip the release edge
    a_locked_gate: assert property (!rst && !unlock |=> secondary_tap_enable == NUM_SEC_TAPS'(4)
        && !test_tap_enable && !boundary_scan_enable) else $error("locked access not gated");
    a_open_gate: assert property (!rst && unlock |=> &secondary_tap_enable && test_tap_enable
        && boundary_scan_enable) else $error("unlocked access gated");
    a_rst_keeps: assert property (disable iff (!power_on_reset_n) rst |=> $stable(unlock))
        else $error("unlock moved by plain reset");
    cover property (rd && dbg_addr == jtag_dbg_pkg::ROM_FRAME_BASE);
    cover property ($fell(unlock));
    cover property ($rose(unlock));
endmodule

// *** test/jtag_debug_security_subsystem_tb.sv ***
// bench of the debug and security subsystem against a behavioural model
// assumes the host model and checker compile ahead of this file
`timescale 1ns/1ps
module jtag_debug_security_subsystem_tb;
    localparam int         BSC = 8;
    localparam logic [3:0] REV = 4'h1;
    logic           sys_clk = 1'b0;
    logic           rst = 1'b1;
    logic           power_on_reset_n = 1'b0;
    logic           tck, tms, tdi, tdo, tdo_oe_n, returned_test_clock, unlock;
    logic [BSC-1:0] bsc_pin_in = '0;
    logic [BSC-1:0] bsc_pin_out;
    logic           otp_prog_we = 1'b0;
    logic [31:0]    otp_prog_addr = '0;
    logic [31:0]    otp_prog_wdata = '0;
    logic [3:0]     secondary_tap_enable;
    logic           test_tap_enable, boundary_scan_enable, dbg_ready, debug_rom_frame_select;
    logic           dbg_sel = 1'b0;
    logic           dbg_write = 1'b0;
    logic [31:0]    dbg_addr = '0;
    logic [31:0]    cpu_debug_rdata = '0;
    logic [31:0]    dbg_rdata, r;
    logic           cpu_debug_frame_select;
    logic [127:0]   code_m, key_m, d, v;
    int             num_errors = 0;
    int             num_checks = 0;
    int             cycles = 0;
    integer         seed = 32'ha60c2494;
    int             rom_m[5] = '{32'h1003, 32'h2002, 32'h3002, 32'h4003, 32'h0};
    always #2.5 sys_clk = ~sys_clk;
    jtag_host_model u_jtag_host_model (.tck, .tms, .tdi, .tdo);
    jtag_debug_security_subsystem #(.NUM_SEC_TAPS(4), .BSC_LEN(BSC), .SILICON_REV(REV))
    u_jtag_debug_security_subsystem (.sys_clk, .rst, .power_on_reset_n, .tck, .tms, .tdi, .tdo, .tdo_oe_n,
        .returned_test_clock, .bsc_pin_in, .bsc_pin_out, .otp_prog_we, .otp_prog_addr, .otp_prog_wdata,
        .unlock, .secondary_tap_enable, .test_tap_enable, .boundary_scan_enable, .dbg_sel, .dbg_write,
        .dbg_addr, .cpu_debug_rdata, .dbg_rdata, .dbg_ready, .debug_rom_frame_select, .cpu_debug_frame_select);
    task automatic cmp(input logic [127:0] got, input logic [127:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("errors %0d, checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [31:0] a);
        logic [31:0] rd, e;
        rd = $random(seed);
        e = (a[31:12] == 20'hffa01) ? rd : (a[31:12] == 20'hffa00 && a[11:2] < 5) ? 32'(rom_m[a[4:2]]) : 32'h0;
        @(posedge sys_clk);
        dbg_sel <= 1'b1;
        dbg_write <= w;
        dbg_addr <= a;
        cpu_debug_rdata <= rd;
        @(posedge sys_clk);
        dbg_sel <= 1'b0;
        #1;
        cmp(dbg_ready, 1'b1);
        if (!w)
            cmp(dbg_rdata, e);
    endtask
    task automatic otp(input logic [31:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        otp_prog_we <= 1'b1;
        otp_prog_addr <= a;
        otp_prog_wdata <= wd;
        @(posedge sys_clk);
        otp_prog_we <= 1'b0;
        if (a[31:4] == 28'hf00_0000)
            code_m[a[3:2]*32 +: 32] &= wd;
    endtask
    task automatic chk;
        logic e;
        e = code_m != '0 && (code_m ^ key_m) == '1;
        for (int i = 0; i < 20 && unlock !== e; i++)
            @(posedge sys_clk);
        repeat (4) @(posedge sys_clk);
        #1;
        cmp(unlock, e);
        cmp(secondary_tap_enable, e ? 4'hf : 4'h4);
        cmp({test_tap_enable, boundary_scan_enable}, {e, e});
        cmp({tdo_oe_n, returned_test_clock}, 2'b10);
    endtask
    task automatic reset(input logic por);
        @(posedge sys_clk);
        rst <= 1'b1;
        power_on_reset_n <= !por;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        power_on_reset_n <= 1'b1;
        if (por) begin
            code_m = '1;
            key_m = '0;
        end
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            results();
        end
    end
    initial begin
        reset(1'b1);
        chk();
        u_jtag_host_model.scan(1'b0, 32, $random(seed), d);
        cmp(d[31:0], {REV, jtag_dbg_pkg::ID_BASE});
        u_jtag_host_model.scan(1'b1, 4, jtag_dbg_pkg::IR_BOUNDARY, d);
        cmp(d[3:0], 4'h1);
        r = $random(seed);
        v = $random(seed);
        @(posedge sys_clk);
        bsc_pin_in <= r[BSC-1:0];
        u_jtag_host_model.scan(1'b0, BSC, v, d);
        cmp(d[BSC-1:0], r[BSC-1:0]);
        repeat (4) @(posedge sys_clk);
        cmp(bsc_pin_out, v[BSC-1:0]);
        for (int i = 0; i < 6; i++)
            bus(1'b0, 32'hffa0_0000 + 4 * i);
        bus(1'b1, 32'hffa0_0004);
        bus(1'b0, 32'hffa0_0004);
        bus(1'b1, 32'hffa0_1010);
        bus(1'b0, 32'hffa0_1000 + {$random(seed)} % 1024 * 4);
        bus(1'b0, 32'hffa0_2000);
        bus(1'b0, 32'hffa0_0ffc);
        otp(32'hf000_0010, 32'h0);
        chk();
        otp(32'hf000_0000, $random(seed) & 32'hffff_fffe);
        chk();
        u_jtag_host_model.scan(1'b1, 4, jtag_dbg_pkg::IR_BOUNDARY, d);
        v = $random(seed);
        u_jtag_host_model.scan(1'b0, 8, v, d);
        cmp(d[7:0], {v[6:0], 1'b0});
        otp(32'hf000_0000, 32'hffff_ffff);
        chk();
        reset(1'b0);
        chk();
        for (int k = 0; k < 2; k++) begin
            u_jtag_host_model.scan(1'b1, 4, jtag_dbg_pkg::IR_KEY, d);
            key_m = ~code_m ^ 128'(k == 0);
            u_jtag_host_model.scan(1'b0, 128, key_m, d);
            chk();
        end
        reset(1'b0);
        chk();
        for (int w = 0; w < 4; w++)
            otp(32'hf000_0000 + 4 * w, 32'h0);
        u_jtag_host_model.scan(1'b1, 4, jtag_dbg_pkg::IR_KEY, d);
        key_m = '1;
        u_jtag_host_model.scan(1'b0, 128, key_m, d);
        chk();
        reset(1'b1);
        chk();
        results();
    end
endmodule
bind jtag_debug_security_subsystem jtag_dbg_asserts #(.NUM_SEC_TAPS(NUM_SEC_TAPS)) u_jtag_dbg_asserts (
    .sys_clk, .rst, .power_on_reset_n, .unlock, .secondary_tap_enable, .test_tap_enable, .boundary_scan_enable,
    .dbg_sel, .dbg_write, .dbg_addr, .cpu_debug_rdata, .dbg_rdata, .dbg_ready, .debug_rom_frame_select,
    .cpu_debug_frame_select);

// *** test/jtag_host_model.sv ***
// host on the scan pins: walks the tap, shifts lsb first, reads tdo
// assumes a 48 ns tck that stands low between frames
`timescale 1ns/1ps
module jtag_host_model (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b0;
        tdi = 1'b0;
    end
    // tdo read late in the high phase, after the fall-launched value settled
    task automatic step(input logic m, input logic b, output logic q);
        tms = m;
        tdi = b;
        tck = 1'b0;
        #24;
        tck = 1'b1;
        #22;
        q = tdo;
        #2;
    endtask
    task automatic scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
        logic q;
        dout = '0;
        step(1'b0, tdi, q);
        step(1'b1, tdi, q);
        if (ir)
            step(1'b1, tdi, q);
        step(1'b0, tdi, q);
        step(1'b0, tdi, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, tdi, q);
        step(1'b0, tdi, q);
        tck = 1'b0;
        tdi = ~tdi;
    endtask
endmodule
